// ==== rtl/cos_pkg.sv ====
`default_nettype none

package cos_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ALARM_COUNT = 36;

  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OUT2_CFG_OFS = 8'h00;
  localparam logic [7:0] OUT3_CFG_OFS = 8'h04;
  localparam logic [7:0] COMM_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FUNC_LSB = 0;
  localparam int NC_BIT = 4;
  localparam int ALARM_LSB = 8;
  localparam int COMM_LSB = 0;
  localparam int ST_OUT2_BIT = 0;
  localparam int ST_OUT3_BIT = 1;
  localparam int ST_IN1_BIT = 2;
  localparam int ST_IN2_BIT = 3;
  localparam int ST_ANY_BIT = 4;
  localparam int ST_SRC2_BIT = 5;
  localparam int ST_SRC3_BIT = 6;

  // ****************************************************************
  // value ranges and polarity codes
  // ****************************************************************
  localparam logic [5:0] ALARM_MIN = 6'h01;
  localparam logic [5:0] ALARM_MAX = 6'h24;
  localparam logic POL_NO = 1'b0;
  localparam logic POL_NC = 1'b1;
  localparam logic [3:0] FUNC_INVALID = 4'hF;
  localparam logic [1:0] COMM_INVALID = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    COS_FN_OFF = 4'b0000,
    COS_FN_RUN = 4'b0001,
    COS_FN_REMOTE = 4'b0010,
    COS_FN_READY = 4'b0011,
    COS_FN_STOP_ALM = 4'b0100,
    COS_FN_CONT_ALM = 4'b0101,
    COS_FN_ANY_ALM = 4'b0110,
    COS_FN_SEL_ALM = 4'b0111,
    COS_FN_RUN_TMR = 4'b1000,
    COS_FN_STOP_TMR = 4'b1001,
    COS_FN_PWR_REC = 4'b1010,
    COS_FN_ANTI_FRZ = 4'b1011,
    COS_FN_PASS1 = 4'b1100,
    COS_FN_PASS2 = 4'b1101,
    COS_FN_FILL = 4'b1110
  } cos_func_t;

  typedef enum logic [1:0] {
    COS_COMM_LOCAL = 2'b00,
    COS_COMM_DISCRETE_IO = 2'b01,
    COS_COMM_SERIAL = 2'b10
  } cos_comm_t;

  typedef struct packed {
    cos_func_t func;
    logic nc;
    logic [5:0] alarm;
  } cos_out_cfg_t;

  typedef struct packed {
    logic run;
    logic remote;
    logic temp_ready;
    logic stop_alarm;
    logic cont_alarm;
    logic run_timer;
    logic stop_timer;
    logic power_recovery;
    logic anti_freeze;
    logic auto_fill_source;
  } cos_status_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cos_req_t;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam cos_out_cfg_t OUT2_RST = '{func: COS_FN_REMOTE, nc: POL_NO, alarm: ALARM_MIN};
  localparam cos_out_cfg_t OUT3_RST = '{func: COS_FN_ANY_ALM, nc: POL_NC, alarm: ALARM_MIN};
  localparam cos_comm_t COMM_RST = COS_COMM_LOCAL;

endpackage

`default_nettype wire

// ==== rtl/cos_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// three-stage input synchroniser; the value moves only when stages two
// and three agree, so a single metastable sample never reaches logic
module cos_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // pin side
  input wire logic pin,
  // synchronous side
  output logic level
);

  logic ff1;
  logic ff2;
  logic ff3;
  logic next_level;

  // accept a change once the last two stages agree
  always_comb begin
    next_level = level;
    if (ff2 == ff3) begin
      next_level = ff3;
    end
  end

  // shift chain; ff1 feeds only ff2
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
      level <= 1'b0;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      level <= next_level;
    end
  end

endmodule // cos_sync

`default_nettype wire

// ==== rtl/cos_top.sv ====
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module cos_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire cos_pkg::cos_req_t bus_req,
  output logic [cos_pkg::DATA_W-1:0] bus_rdata,
  // internal status sources, same clock
  input wire cos_pkg::cos_status_t status,
  input wire logic [cos_pkg::ALARM_COUNT-1:0] alarm_active,
  // contact inputs from the customer, asynchronous pins
  input wire logic contact_in1,
  input wire logic contact_in2,
  // contact outputs, index 0 is output 2, index 1 is output 3
  output logic [1:0] contact_out,
  // selected communication mode
  output cos_pkg::cos_comm_t comm_mode,
  output logic discrete_io_mode
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  // stored settings, index 0 is output 2 and index 1 is output 3
  cos_pkg::cos_out_cfg_t [1:0] cfg;
  cos_pkg::cos_out_cfg_t [1:0] next_cfg;
  cos_pkg::cos_comm_t next_comm_mode;
  logic next_discrete_io_mode;
  // read path
  logic [cos_pkg::DATA_W-1:0] next_bus_rdata;
  // contact path, before and after polarity
  logic [1:0] next_contact_out;
  logic [1:0] src_level;
  // conditioned pins and the alarm summary
  logic [1:0] in_level;
  logic any_alarm;

  // ****************************************************************
  // functions
  // ****************************************************************

  // true when the alarm number lies in the legal window
  function automatic logic alarm_in_range(input logic [5:0] num);
    alarm_in_range = (num >= cos_pkg::ALARM_MIN) && (num <= cos_pkg::ALARM_MAX);
  endfunction

  // merge a write into one output's settings
  // the lock looks at the source stored before this write, so software
  // picks the selected-alarm source first and sets the number after
  function automatic cos_pkg::cos_out_cfg_t cfg_write(
    input cos_pkg::cos_out_cfg_t cur,
    input logic [cos_pkg::DATA_W-1:0] wd
  );
    logic [3:0] fn;
    logic [5:0] num;
    cfg_write = cur;
    fn = wd[cos_pkg::FUNC_LSB +: 4];
    num = wd[cos_pkg::ALARM_LSB +: 6];
    // unused code 15 leaves the source as it was
    // but the polarity bit still lands, so one word can flip polarity alone
    if (fn != cos_pkg::FUNC_INVALID) begin
      cfg_write.func = cos_pkg::cos_func_t'(fn);
    end
    cfg_write.nc = wd[cos_pkg::NC_BIT];
    // locked unless the stored source is the selected alarm
    if ((cur.func == cos_pkg::COS_FN_SEL_ALM) && alarm_in_range(num)) begin
      cfg_write.alarm = num;
    end
  endfunction

  // read image of one output's settings
  function automatic logic [cos_pkg::DATA_W-1:0] cfg_read(
    input cos_pkg::cos_out_cfg_t cur
  );
    cfg_read = '0;
    cfg_read[cos_pkg::FUNC_LSB +: 4] = cur.func;
    cfg_read[cos_pkg::NC_BIT] = cur.nc;
    // hidden while another source is chosen
    if (cur.func == cos_pkg::COS_FN_SEL_ALM) begin
      cfg_read[cos_pkg::ALARM_LSB +: 6] = cur.alarm;
    end
  endfunction

  // one output's logical source before polarity
  // the alarm index is used only once the range guard has passed, so a
  // number outside the window can never read past the alarm vector
  function automatic logic pick_source(
    input cos_pkg::cos_out_cfg_t cur,
    input cos_pkg::cos_status_t st,
    input logic [cos_pkg::ALARM_COUNT-1:0] alm,
    input logic any,
    input logic [1:0] ins
  );
    logic [5:0] idx;
    idx = cur.alarm - cos_pkg::ALARM_MIN;
    case (cur.func)
      cos_pkg::COS_FN_OFF: begin
        pick_source = 1'b0;
      end
      cos_pkg::COS_FN_RUN: begin
        pick_source = st.run;
      end
      cos_pkg::COS_FN_REMOTE: begin
        pick_source = st.remote;
      end
      cos_pkg::COS_FN_READY: begin
        pick_source = st.temp_ready;
      end
      cos_pkg::COS_FN_STOP_ALM: begin
        pick_source = st.stop_alarm;
      end
      cos_pkg::COS_FN_CONT_ALM: begin
        pick_source = st.cont_alarm;
      end
      cos_pkg::COS_FN_ANY_ALM: begin
        pick_source = any;
      end
      cos_pkg::COS_FN_SEL_ALM: begin
        // guard keeps the index inside the vector
        // a stale out-of-range number reads as inactive
        if (alarm_in_range(cur.alarm)) begin
          pick_source = alm[idx];
        end else begin
          pick_source = 1'b0;
        end
      end
      cos_pkg::COS_FN_RUN_TMR: begin
        pick_source = st.run_timer;
      end
      cos_pkg::COS_FN_STOP_TMR: begin
        pick_source = st.stop_timer;
      end
      cos_pkg::COS_FN_PWR_REC: begin
        pick_source = st.power_recovery;
      end
      cos_pkg::COS_FN_ANTI_FRZ: begin
        pick_source = st.anti_freeze;
      end
      cos_pkg::COS_FN_PASS1: begin
        pick_source = ins[0];
      end
      cos_pkg::COS_FN_PASS2: begin
        pick_source = ins[1];
      end
      cos_pkg::COS_FN_FILL: begin
        pick_source = st.auto_fill_source;
      end
      default: begin
        pick_source = 1'b0;
      end
    endcase
  endfunction

  // ****************************************************************
  // contact input conditioning
  // ****************************************************************

  // pins come from the customer's side, so each passes a synchroniser
  // the pins are also readable in the status word for wiring checks
  cos_sync u_sync_in1 (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(contact_in1),
    .level(in_level[0])
  );

  cos_sync u_sync_in2 (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(contact_in2),
    .level(in_level[1])
  );

  // ****************************************************************
  // alarm summary
  // ****************************************************************

  // any single active alarm raises the summary
  // plain or-reduction, nothing latched: the summary follows the inputs
  assign any_alarm = |alarm_active;

  // ****************************************************************
  // configuration registers
  // ****************************************************************

  // write decode; a write to an unmapped offset is dropped
  // a write is one cycle, so new settings show from the next edge
  always_comb begin
    next_cfg = cfg;
    next_comm_mode = comm_mode;
    if (bus_req.wr) begin
      if (bus_req.addr == cos_pkg::OUT2_CFG_OFS) begin
        next_cfg[0] = cfg_write(cfg[0], bus_req.wdata);
      end else if (bus_req.addr == cos_pkg::OUT3_CFG_OFS) begin
        next_cfg[1] = cfg_write(cfg[1], bus_req.wdata);
      end else if (bus_req.addr == cos_pkg::COMM_OFS) begin
        // reserved code 3 keeps the current mode
        if (bus_req.wdata[cos_pkg::COMM_LSB +: 2] != cos_pkg::COMM_INVALID) begin
          next_comm_mode = cos_pkg::cos_comm_t'(bus_req.wdata[cos_pkg::COMM_LSB +: 2]);
        end
      end
    end
  end

  // settings take their defaults in reset and hold them until written
  // the reset level of every setting is a package constant
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg[0] <= cos_pkg::OUT2_RST;
      cfg[1] <= cos_pkg::OUT3_RST;
      comm_mode <= cos_pkg::COMM_RST;
      discrete_io_mode <= (cos_pkg::COMM_RST == cos_pkg::COS_COMM_DISCRETE_IO);
    end else begin
      cfg <= next_cfg;
      comm_mode <= next_comm_mode;
      discrete_io_mode <= next_discrete_io_mode;
    end
  end

  // flag for the discrete io mode, decoded ahead of the register so the
  // flag leaves a flip-flop and moves in the same cycle as the mode
  assign next_discrete_io_mode = (next_comm_mode == cos_pkg::COS_COMM_DISCRETE_IO);

  // ****************************************************************
  // read port
  // ****************************************************************

  // read data stand for exactly one cycle after the strobe
  // status bits are a snapshot of the cycle in which the strobe is seen
  always_comb begin
    next_bus_rdata = '0;
    if (bus_req.rd) begin
      if (bus_req.addr == cos_pkg::OUT2_CFG_OFS) begin
        next_bus_rdata = cfg_read(cfg[0]);
      end else if (bus_req.addr == cos_pkg::OUT3_CFG_OFS) begin
        next_bus_rdata = cfg_read(cfg[1]);
      end else if (bus_req.addr == cos_pkg::COMM_OFS) begin
        next_bus_rdata[cos_pkg::COMM_LSB +: 2] = comm_mode;
      end else if (bus_req.addr == cos_pkg::STATUS_OFS) begin
        next_bus_rdata[cos_pkg::ST_OUT2_BIT] = contact_out[0];
        next_bus_rdata[cos_pkg::ST_OUT3_BIT] = contact_out[1];
        next_bus_rdata[cos_pkg::ST_IN1_BIT] = in_level[0];
        next_bus_rdata[cos_pkg::ST_IN2_BIT] = in_level[1];
        next_bus_rdata[cos_pkg::ST_ANY_BIT] = any_alarm;
        next_bus_rdata[cos_pkg::ST_SRC2_BIT] = src_level[0];
        next_bus_rdata[cos_pkg::ST_SRC3_BIT] = src_level[1];
      end
    end
  end

  // read data register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= next_bus_rdata;
    end
  end

  // ****************************************************************
  // contact output drive
  // ****************************************************************

  // both outputs share the same selector and polarity stage
  // limitation: a pin change takes about five edges to reach the contact,
  // three synchroniser stages, one to agree and this output register
  for (genvar gi = 0; gi < 2; gi++) begin : g_out
    always_comb begin
      src_level[gi] = pick_source(cfg[gi], status, alarm_active, any_alarm, in_level);
      // polarity as a final xor; inactive source still honours it
      next_contact_out[gi] = src_level[gi] ^ cfg[gi].nc;
    end
  end

  // registered contacts; the reset level equals the default polarity
  // with an inactive source, so no glitch on leaving reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      contact_out[0] <= cos_pkg::OUT2_RST.nc;
      contact_out[1] <= cos_pkg::OUT3_RST.nc;
    end else begin
      contact_out <= next_contact_out;
    end
  end

endmodule // cos_top

`default_nettype wire

// ==== tb/cos_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module cos_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire cos_pkg::cos_req_t bus_req,
  input wire logic [cos_pkg::DATA_W-1:0] bus_rdata,
  // sources and pins
  input wire cos_pkg::cos_status_t status,
  input wire logic [cos_pkg::ALARM_COUNT-1:0] alarm_active,
  input wire logic contact_in1,
  input wire logic contact_in2,
  // results
  input wire logic [1:0] contact_out,
  input wire cos_pkg::cos_comm_t comm_mode,
  input wire logic discrete_io_mode
);
  // decoded strobes
  wire logic wr_cm = bus_req.wr && bus_req.addr == cos_pkg::COMM_OFS;
  wire logic wr_o2 = bus_req.wr && bus_req.addr == cos_pkg::OUT2_CFG_OFS;
  wire logic rd_o2 = bus_req.rd && bus_req.addr == cos_pkg::OUT2_CFG_OFS;
  wire logic rd_st = bus_req.rd && bus_req.addr == cos_pkg::STATUS_OFS;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_RST_VAL: assert property (disable iff (1'b0)
    reset |-> contact_out == 2'b10 && comm_mode == cos_pkg::COS_COMM_LOCAL)
    else $error("outputs not at defaults in reset");
  AST_DIO_DEC: assert property (
    discrete_io_mode == (comm_mode == cos_pkg::COS_COMM_DISCRETE_IO))
    else $error("discrete io flag disagrees with mode");
  AST_COMM_OK: assert property (comm_mode != cos_pkg::COMM_INVALID)
    else $error("illegal mode held");
  AST_COMM_WR: assert property (wr_cm && bus_req.wdata[1:0] != 2'h3
    |=> comm_mode == $past(bus_req.wdata[1:0])) else $error("mode write lost");
  AST_COMM_HOLD: assert property (!wr_cm |=> $stable(comm_mode))
    else $error("mode moved without a write");
  AST_ANY: assert property (rd_st && $stable(alarm_active)
    |=> bus_rdata[cos_pkg::ST_ANY_BIT] == |$past(alarm_active))
    else $error("any alarm bit wrong");
  AST_CFG_RB: assert property (
    wr_o2 && bus_req.wdata[3:0] != 4'hF ##1 !bus_req.wr ##1 rd_o2
    |=> bus_rdata[4:0] == $past(bus_req.wdata[4:0], 3))
    else $error("function or polarity not stored");
  AST_OUT_CAUSE: assert property ($changed(contact_out) |->
    $past(bus_req.wr, 2) || $past(status) != $past(status, 2)
    || $past(alarm_active) != $past(alarm_active, 2)
    || $past(contact_in1, 8) != contact_in1 || $past(contact_in2, 8) != contact_in2)
    else $error("contact moved with no cause");
endmodule // cos_asserts

bind cos_top cos_asserts u_asserts (.sys_clk(sys_clk), .reset(reset),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .status(status),
  .alarm_active(alarm_active), .contact_in1(contact_in1),
  .contact_in2(contact_in2), .contact_out(contact_out),
  .comm_mode(comm_mode), .discrete_io_mode(discrete_io_mode));
`default_nettype wire

// ==== tb/cos_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// customer equipment
// ****
module cos_partner (
  // clock
  input wire logic sys_clk,
  // wanted input levels
  input wire logic [1:0] want_in,
  // contact input pins
  output logic contact_in1,
  output logic contact_in2
);
  // pins move off the edge, like a relay, so sync timing is exercised
  initial begin
    contact_in1 = 1'b0;
    contact_in2 = 1'b0;
  end
  always @(posedge sys_clk) begin
    #2;
    contact_in1 = want_in[0];
    contact_in2 = want_in[1];
  end
endmodule // cos_partner
`default_nettype wire

// ==== tb/cos_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module cos_top_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b0;
  cos_pkg::cos_req_t bus_req = '0;
  cos_pkg::cos_status_t status = '0;
  logic [35:0] alarm_active = '0;
  logic [1:0] want_in = 2'b00;
  logic [31:0] bus_rdata;
  logic [1:0] contact_out;
  cos_pkg::cos_comm_t comm_mode;
  logic discrete_io_mode, contact_in1, contact_in2;
  int bad_count = 0;
  int compares = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  cos_top dut (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .status(status), .alarm_active(alarm_active),
    .contact_in1(contact_in1), .contact_in2(contact_in2),
    .contact_out(contact_out), .comm_mode(comm_mode),
    .discrete_io_mode(discrete_io_mode));
  cos_partner u_cust (.sys_clk(sys_clk), .want_in(want_in),
    .contact_in1(contact_in1), .contact_in2(contact_in2));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    cmp(bus_rdata, exp);
  endtask
  // pin path is the slowest, about five edges
  task automatic settle();
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // raise one source; code 0 raises everything instead
  task automatic drive_src(input int code, input logic v);
    logic [9:0] st;
    logic [35:0] al;
    logic [1:0] pin;
    @(posedge sys_clk);
    st = {10{code == 0}};
    al = {36{code == 0}};
    pin = {2{code == 0}};
    case (code)
      1, 2, 3, 4, 5: st[10 - code] = v;
      8, 9, 10, 11: st[12 - code] = v;
      14: st[0] = v;
      6: al[35] = v;
      7: al[0] = v;
      12: pin[0] = v;
      13: pin[1] = v;
      default: ;
    endcase
    status <= st;
    alarm_active <= al;
    want_in <= pin;
  endtask
  task automatic t_defaults();
    drive_src(15, 1'b0);
    bus_req <= '0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk(8'h00, 32'h00000002);
    rd_chk(8'h04, 32'h00000016);
    rd_chk(8'h08, 32'h00000000);
    settle();
    cmp({30'h0, contact_out}, 32'h00000002);
    @(posedge sys_clk);
    status.remote <= 1'b1;
    alarm_active[3] <= 1'b1;
    settle();
    cmp({30'h0, contact_out}, 32'h00000001);
    rd_chk(8'h0C, 32'h00000071);
    $display("test defaults done");
  endtask
  task automatic t_sources();
    for (int o = 0; o < 2; o++) begin
      for (int c = 0; c < 15; c++) begin
        bus_wr(o ? 8'h04 : 8'h00, {27'h0, o[0], c[3:0]});
        for (int v = 0; v < 2; v++) begin
          drive_src(c, v[0]);
          settle();
          chk_bit(contact_out[o], (v[0] && c != 0) ^ o[0]);
        end
      end
    end
    bus_wr(8'h04, 32'h0000001F);
    rd_chk(8'h04, 32'h0000001E);
    $display("test sources done");
  endtask
  task automatic t_sel_alarm();
    drive_src(15, 1'b0);
    bus_wr(8'h00, 32'h00000502);
    bus_wr(8'h00, 32'h00000507);
    rd_chk(8'h00, 32'h00000107);
    bus_wr(8'h00, 32'h00000507);
    rd_chk(8'h00, 32'h00000507);
    bus_wr(8'h00, 32'h00002507);
    rd_chk(8'h00, 32'h00000507);
    @(posedge sys_clk);
    alarm_active <= 36'h000000010;
    settle();
    chk_bit(contact_out[0], 1'b1);
    bus_wr(8'h00, 32'h00002407);
    settle();
    chk_bit(contact_out[0], 1'b0);
    bus_wr(8'h00, 32'h00002402);
    rd_chk(8'h00, 32'h00000002);
    $display("test selected alarm done");
  endtask
  task automatic t_comm();
    int e;
    for (int m = 0; m < 4; m++) begin
      e = (m == 3) ? 2 : m;
      bus_wr(8'h08, m);
      rd_chk(8'h08, e);
      cmp({30'h0, comm_mode}, e);
      chk_bit(discrete_io_mode, m == 1);
    end
    $display("test comm mode done");
  endtask
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence, reset raised off the clock edge before the first one
  initial begin
    #1;
    reset = 1'b1;
    t_defaults();
    t_sources();
    t_sel_alarm();
    t_comm();
    @(posedge sys_clk);
    reset <= 1'b1;
    t_defaults();
    print_verdict();
  end
  // watchdog: the tests take about 740 cycles
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule // cos_top_tb_top
`default_nettype wire
